// *** pkg/erb_pkg.sv ***
// Purpose: Shared constants for the emulation reset and bus select block
// Assumes: 125 MHz core clock, active-low reset, request and grant pins; emulator enable active high
// Notes:   Mode pin count and synchroniser depth live here
`default_nettype none
package erb_pkg;
   localparam int          MODE_W      = 3;        // Memory-mode select pins A, B, C
   localparam int          SYNC_DEPTH  = 3;        // Flip-flops on each pin input
   localparam int          MODE_C_BIT  = 2;        // Third mode pin, shared with flag 2
   localparam int          CLK_MHZ     = 125;      // Core clock rate
   localparam int          RST_LOW_NS  = 40;       // Least reset low width, five 8 ns cycles
   localparam int          RST_LOW_CYC = (RST_LOW_NS * CLK_MHZ + 999) / 1000;
   localparam logic [2:0]  MODE_RST    = 3'h0;     // Mode latch value before first capture
   localparam logic [3:0]  CNT_W4_ZERO = 4'h0;     // Counter clear value
   localparam logic        PIN_HIGH    = 1'b1;     // Inactive level of an active-low pin
   // Reset sequencing state: running, waiting in reset, capturing the mode
   typedef enum logic [1:0] {
      ERB_RUN      = 2'b00,
      ERB_IN_RESET = 2'b01,
      ERB_CAPTURE  = 2'b10
   } erb_state_t;
endpackage
`default_nettype wire

// *** core/erb_sync.sv ***
// Purpose: Three-stage synchroniser with agree-to-change filter
// Assumes: Input comes from a pin outside the clock domain
// Notes:   Output changes only when stages two and three agree
`default_nettype none
module erb_sync #(
   parameter int   DEPTH     = erb_pkg::SYNC_DEPTH,
   parameter logic RST_VAL   = erb_pkg::PIN_HIGH
) (
   input  wire logic clock,
   input  wire logic resetn,
   input  wire logic pin_in,
   output var  logic level_out
);
   logic [DEPTH-1:0] stage_r;    // Shift chain, bit 0 is the first stage
   logic [DEPTH-1:0] stage_nxt;
   logic             level_r;    // Filtered level
   logic             level_nxt;

   // Next-state: shift in and accept a change once the last two stages agree
   always_comb begin
      stage_nxt = {stage_r[DEPTH-2:0], pin_in};
      level_nxt = level_r;
      // A lone sample on a metastable edge never reaches the output
      if (stage_r[DEPTH-2] == stage_r[DEPTH-1]) begin
         level_nxt = stage_r[DEPTH-1];
      end
   end

   // Registers only; first stage read solely by the second
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         stage_r <= {DEPTH{RST_VAL}};
         level_r <= RST_VAL;
      end else begin
         stage_r <= stage_nxt;
         level_r <= level_nxt;
      end
   end

   assign level_out = level_r;
endmodule
`default_nettype wire

// *** core/erb_emu_select.sv ***
// Purpose: Emulator takeover of reset and bus request/grant, mode pin latch
// Assumes: All pin inputs asynchronous; one 125 MHz clock; resetn is power-on reset
// Notes:   Chip reset and mode capture driven by whichever reset source is selected
//
// What this block does
// [RL1] Latch mode pins on normal reset rising edge
// [RL2] Emulator reset resets chip, recaptures mode pins
// [RL3] Emulator enable selects emulator reset/request/grant
// [RL4] Normal grant output floats under emulation
// [RL5] Emulation pins ignored unless emulation active
// [RL6] Emulator ignores target reset/request while stepping
// [RL7] Target takes bus only after emulator grant
// [RL8] Target should hold third mode pin low
// [RL9] Mode C driven only during reset, then released
// [RL10] Without enable, only normal pins are used
`default_nettype none
module erb_emu_select #(
   parameter int MODE_W = erb_pkg::MODE_W
) (
   input  wire logic              clock,
   input  wire logic              resetn,
   input  wire logic              reset_pin_n,
   input  wire logic              emu_reset_n,
   input  wire logic              emulator_enable,
   input  wire logic              bus_request_n,
   input  wire logic              emu_bus_request_n,
   input  wire logic [MODE_W-1:0] mode_pins,
   input  wire logic              core_grant,
   output var  logic              chip_reset_n,
   output var  logic              core_bus_request,
   output var  logic              bus_grant_n,
   output var  logic              bus_grant_oe,
   output var  logic              emu_bus_grant_n,
   output var  logic [MODE_W-1:0] mode_latched,
   output var  logic              mode_valid
);
   logic              nrst_s;        // Synchronised normal reset
   logic              erst_s;        // Synchronised emulator reset
   logic              ee_s;          // Synchronised emulator enable
   logic              nbr_s;         // Synchronised normal bus request
   logic              ebr_s;         // Synchronised emulator bus request
   logic [MODE_W-1:0] mode_s;        // Synchronised mode pins
   logic              sel_rst_n;     // Reset from the selected source
   logic              sel_br_n;      // Bus request from the selected source


   // Sequencing state and every top output, each with its next value
   erb_pkg::erb_state_t state_r;              // Reset sequencing state
   erb_pkg::erb_state_t state_nxt;
   logic                chip_reset_n_r;       // Chip reset to the core
   logic                chip_reset_n_nxt;
   logic                core_bus_request_r;   // Request to the core, active high
   logic                core_bus_request_nxt;
   logic                bus_grant_n_r;        // Grant to the target side
   logic                bus_grant_n_nxt;
   logic                bus_grant_oe_r;       // High while the target grant is driven
   logic                bus_grant_oe_nxt;
   logic                emu_bus_grant_n_r;    // Grant to the pod
   logic                emu_bus_grant_n_nxt;
   logic [MODE_W-1:0]   mode_latched_r;       // Boot mode held for the core
   logic [MODE_W-1:0]   mode_latched_nxt;
   logic                mode_valid_r;         // Mode latch holds a fresh capture
   logic                mode_valid_nxt;

   // Chooses the pod-side level while the pod holds control, else the target side
   function automatic logic pick_source(
      input logic emu_on,
      input logic emu_level,
      input logic normal_level
   );
      logic chosen;
      chosen = normal_level;
      if (emu_on) begin
         chosen = emu_level;
      end
      return chosen;
   endfunction

   // Reset pins power up asserted, so the core never sees a false run
   // before the synchronisers have settled on the real pin level
   erb_sync #(
      .DEPTH   (erb_pkg::SYNC_DEPTH),
      .RST_VAL (~erb_pkg::PIN_HIGH)
   ) i_sync_nrst (
      .clock     (clock),
      .resetn    (resetn),
      .pin_in    (reset_pin_n),
      .level_out (nrst_s)
   );

   // Emulator reset, same treatment as the normal reset
   erb_sync #(
      .DEPTH   (erb_pkg::SYNC_DEPTH),
      .RST_VAL (~erb_pkg::PIN_HIGH)
   ) i_sync_erst (
      .clock     (clock),
      .resetn    (resetn),
      .pin_in    (emu_reset_n),
      .level_out (erst_s)
   );

   // Emulator enable powers up off: the target owns the chip until the pod says so
   erb_sync #(
      .DEPTH   (erb_pkg::SYNC_DEPTH),
      .RST_VAL (~erb_pkg::PIN_HIGH)
   ) i_sync_ee (
      .clock     (clock),
      .resetn    (resetn),
      .pin_in    (emulator_enable),
      .level_out (ee_s)
   );

   // Target bus request, idle high
   erb_sync #(
      .DEPTH   (erb_pkg::SYNC_DEPTH),
      .RST_VAL (erb_pkg::PIN_HIGH)
   ) i_sync_nbr (
      .clock     (clock),
      .resetn    (resetn),
      .pin_in    (bus_request_n),
      .level_out (nbr_s)
   );

   // Pod bus request, idle high
   erb_sync #(
      .DEPTH   (erb_pkg::SYNC_DEPTH),
      .RST_VAL (erb_pkg::PIN_HIGH)
   ) i_sync_ebr (
      .clock     (clock),
      .resetn    (resetn),
      .pin_in    (emu_bus_request_n),
      .level_out (ebr_s)
   );

   // Mode pins share the reset pins' latency, so a mode value released
   // together with reset is never seen before reset itself rises
   genvar gi;
   generate
      for (gi = 0; gi < MODE_W; gi++) begin : g_mode_sync
         erb_sync #(
            .DEPTH   (erb_pkg::SYNC_DEPTH),
            .RST_VAL (erb_pkg::PIN_HIGH)
         ) i_sync_mode (
            .clock     (clock),
            .resetn    (resetn),
            .pin_in    (mode_pins[gi]),
            .level_out (mode_s[gi])
         );
      end
   endgenerate

   // Source selection; the unselected side has no effect at all
   always_comb begin
      sel_rst_n = pick_source(ee_s, erst_s, nrst_s); // RL2 RL3 RL5 RL10
      sel_br_n  = pick_source(ee_s, ebr_s, nbr_s);   // RL3 RL5 RL10
   end

   // Next-state: reset sequencing and mode capture
   always_comb begin
      state_nxt        = state_r;
      mode_latched_nxt = mode_latched_r;
      mode_valid_nxt   = mode_valid_r;
      chip_reset_n_nxt = sel_rst_n;                  // RL2
      // Track the mode pins only while reset is low; the shared flag pin
      // is free again once reset rises, so its later activity is ignored
      if (!sel_rst_n) begin
         mode_latched_nxt = mode_s;                  // RL1 RL2 RL9
         mode_valid_nxt   = 1'b0;                    // RL2
      end
      unique case (state_r)
         // Waiting for the selected reset to rise
         erb_pkg::ERB_IN_RESET: begin
            if (sel_rst_n) begin
               state_nxt = erb_pkg::ERB_CAPTURE;
            end
         end
         // Rising edge seen; the last in-reset sample is now frozen
         erb_pkg::ERB_CAPTURE: begin
            if (sel_rst_n) begin
               mode_valid_nxt = 1'b1;                // RL1
               state_nxt      = erb_pkg::ERB_RUN;
            end else begin
               state_nxt = erb_pkg::ERB_IN_RESET;
            end
         end
         // Running; any reset from the selected source starts over
         erb_pkg::ERB_RUN: begin
            if (!sel_rst_n) begin
               state_nxt = erb_pkg::ERB_IN_RESET;    // RL2
            end
         end
         // Unused code: fall back to reset
         default: begin
            state_nxt = erb_pkg::ERB_IN_RESET;
         end
      endcase
   end

   // Next-state: bus request and grant steering
   always_comb begin
      core_bus_request_nxt = ~sel_br_n;              // RL3 RL10
      bus_grant_n_nxt      = erb_pkg::PIN_HIGH;
      bus_grant_oe_nxt     = 1'b0;
      emu_bus_grant_n_nxt  = erb_pkg::PIN_HIGH;      // RL5
      if (ee_s) begin
         // Pod in control: target grant floats, pod sees the grant
         emu_bus_grant_n_nxt = ~core_grant;          // RL3 RL4
      end else begin
         // Target in control: pod grant stays idle
         bus_grant_n_nxt  = ~core_grant;             // RL10
         bus_grant_oe_nxt = 1'b1;                    // RL10
      end
   end

   // Registers only; the reset branch loads constants
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         state_r            <= erb_pkg::ERB_IN_RESET;
         chip_reset_n_r     <= ~erb_pkg::PIN_HIGH;
         core_bus_request_r <= 1'b0;
         bus_grant_n_r      <= erb_pkg::PIN_HIGH;
         bus_grant_oe_r     <= 1'b1;
         emu_bus_grant_n_r  <= erb_pkg::PIN_HIGH;
         mode_latched_r     <= MODE_W'(erb_pkg::MODE_RST);
         mode_valid_r       <= 1'b0;
      end else begin
         state_r            <= state_nxt;
         chip_reset_n_r     <= chip_reset_n_nxt;
         core_bus_request_r <= core_bus_request_nxt;
         bus_grant_n_r      <= bus_grant_n_nxt;
         bus_grant_oe_r     <= bus_grant_oe_nxt;
         emu_bus_grant_n_r  <= emu_bus_grant_n_nxt;
         mode_latched_r     <= mode_latched_nxt;
         mode_valid_r       <= mode_valid_nxt;
      end
   end

   // Every output straight from its flip-flop
   assign chip_reset_n     = chip_reset_n_r;
   assign core_bus_request = core_bus_request_r;
   assign bus_grant_n      = bus_grant_n_r;
   assign bus_grant_oe     = bus_grant_oe_r;
   assign emu_bus_grant_n  = emu_bus_grant_n_r;
   assign mode_latched     = mode_latched_r;
   assign mode_valid       = mode_valid_r;

   // Mode latch frozen whenever the selected reset is high
   AST_MODE_HOLD: assert property (@(posedge clock) disable iff (!resetn) // RL1
      sel_rst_n |=> $stable(mode_latched))
      else $error("mode latch moved outside reset");
   // Selected reset reaches the core next cycle
   AST_RESET_FOLLOW: assert property (@(posedge clock) disable iff (!resetn) // RL2
      !sel_rst_n |=> !chip_reset_n)
      else $error("chip reset not asserted");
   // A new reset discards the held mode
   AST_VALID_DROP: assert property (@(posedge clock) disable iff (!resetn) // RL2
      !sel_rst_n |=> !mode_valid)
      else $error("mode valid kept through reset");
   // Selected request reaches the core
   AST_REQ_ON: assert property (@(posedge clock) disable iff (!resetn) // RL3
      !sel_br_n |=> core_bus_request)
      else $error("bus request not passed");
   // Idle selected request keeps the core quiet
   AST_REQ_OFF: assert property (@(posedge clock) disable iff (!resetn) // RL3
      sel_br_n |=> !core_bus_request)
      else $error("bus request without source");
   // Target grant floats under emulation
   AST_GRANT_FLOAT: assert property (@(posedge clock) disable iff (!resetn) // RL4
      ee_s |=> !bus_grant_oe)
      else $error("target grant driven under emulation");
   // Pod grant idle outside emulation
   AST_EMU_GRANT_IDLE: assert property (@(posedge clock) disable iff (!resetn) // RL5
      !ee_s |=> emu_bus_grant_n)
      else $error("pod grant active outside emulation");
   // Target grant driven outside emulation
   AST_GRANT_DRIVE: assert property (@(posedge clock) disable iff (!resetn) // RL10
      !ee_s |=> bus_grant_oe)
      else $error("target grant not driven");

   // Main scenarios: capture, pod takeover, pod reset
   COV_CAPTURE: cover property (@(posedge clock) disable iff (!resetn)
      state_r == erb_pkg::ERB_CAPTURE ##1 mode_valid);
   COV_TAKEOVER: cover property (@(posedge clock) disable iff (!resetn)
      ee_s ##1 !bus_grant_oe);
   COV_EMU_RESET: cover property (@(posedge clock) disable iff (!resetn)
      ee_s && !erst_s);
endmodule
`default_nettype wire

// *** verification/erb_target_model.sv ***
// Purpose: Target boot-mode driver model
// Assumes: Driver enabled only while a reset is low
// Notes:   Released pins toggle each clock, which the agree filter never passes, so mode_s keeps the driven value
`default_nettype none
module erb_target_model (
   input  wire logic       clock,
   input  wire logic       drive_n,
   input  wire logic [2:0] mode_val,
   output var  logic [2:0] mode_pins
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] junk_r = 3'h0; // Pattern once released
   always_ff @(posedge clock) junk_r <= ~junk_r;
   assign mode_pins = drive_n ? junk_r : mode_val;
endmodule
`default_nettype wire

// *** verification/emulation_reset_bus_select_test.sv ***
// Purpose: Bench for emulator reset and bus select
// Assumes: Outputs settle within a few cycles
// Notes:   Fixed waits cover the input synchronisers
`default_nettype none
module emulation_reset_bus_select_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 0, resetn = 0, rst_n = 0, erst_n = 1, ee = 0, br_n = 1, ebr_n = 1, gnt = 0;
   logic [2:0] mval = 3'h5, mp, ml;
   logic crn, creq, bg_n, bg_oe, ebg_n, mv;
   int miscompares = 0, tests_run = 0;
   always #4 clock = ~clock;
   erb_target_model i_tgt (.clock, .drive_n(rst_n & erst_n), .mode_val(mval), .mode_pins(mp));
   erb_emu_select i_dut (.clock, .resetn, .reset_pin_n(rst_n), .emu_reset_n(erst_n),
      .emulator_enable(ee), .bus_request_n(br_n), .emu_bus_request_n(ebr_n), .mode_pins(mp),
      .core_grant(gnt), .chip_reset_n(crn), .core_bus_request(creq), .bus_grant_n(bg_n),
      .bus_grant_oe(bg_oe), .emu_bus_grant_n(ebg_n), .mode_latched(ml), .mode_valid(mv));
   task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
      tests_run++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
   endtask
   task automatic end_of_test;
      $display("mismatches %0d of %0d", miscompares, tests_run);
      if (miscompares == 0 && tests_run > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // Normal reset then normal bus, emulator pins ignored
   task automatic normal_mode;
      rst_n <= 1;
      gnt <= 1;
      br_n <= 0;
      cyc(12);
      chk({mv, ml}, 4'hd);
      chk({3'h0, crn}, 4'h1);
      chk({1'b0, creq, bg_n, bg_oe}, 4'h5);
      chk({3'h0, ebg_n}, 4'h1);
      br_n <= 1;
      ebr_n <= 0;
      cyc(8);
      chk({3'h0, creq}, 4'h0);
   endtask
   // Emulator takes over, then its reset recaptures modes
   task automatic emu_mode;
      ee <= 1;
      cyc(8);
      chk({1'b0, creq, bg_oe, ebg_n}, 4'h4);
      // Pod ignores target reset and request while it holds control
      rst_n <= 0;
      br_n <= 0;
      ebr_n <= 1;
      cyc(8);
      chk({2'h0, creq, crn}, 4'h1);
      chk({1'b0, ml}, 4'h5);
      rst_n <= 1;
      br_n <= 1;
      cyc(4);
      mval <= 3'h3;
      erst_n <= 0;
      cyc(8);
      chk({2'h0, crn, mv}, 4'h0);
      erst_n <= 1;
      cyc(12);
      chk({1'b0, ml}, 4'h3);
      chk({3'h0, mv}, 4'h1);
   endtask
   initial begin
      cyc(8);
      resetn <= 1;
      cyc(4);
      normal_mode();
      emu_mode();
      end_of_test();
   end
   initial begin
      #100000;
      miscompares++;
      end_of_test();
   end
endmodule
`default_nettype wire
